// [core/spic_control.sv]
// Serial port control, status flags, clock-rate divider and shift engine.
// Assumes the core reaches it over the special function register bus and
// that configuration bits arrive as plain inputs.
// How it works
// - Transfer end sets done flag and raises the interrupt request when enabled.
// - Status flags stay set until software clears them.
// - Data write while transmit buffer full sets the collision flag.
// - A colliding write is dropped; the transmit buffer keeps its byte.
// - Select low with master on and mode 01 sets the mode fault flag.
// - Slave last bit in while receive buffer unread sets overrun.
// - Mode 00 is three-wire; the select pin is left alone.
// - Mode 01, the reset value, uses the select pin as input.
// - Mode 1x drives the select pin with the low mode bit.
// - Writing the transmit buffer clears the buffer-empty bit.
// - Moving the buffer into the shifter sets buffer-empty again.
// - Enable bit turns the port on; it resets to zero.
// - Master clock is system clock over two times the sum of divider and one.
// - Control register is written byte-wide or bit by bit, page zero.
// - Master data write loads buffer and starts; read returns receive buffer.
// - Master enable input picks master when high, slave when low.
`timescale 1ns/10ps
`default_nettype none
module spic_control (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] sfr_page,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_bit_wr,
	input  wire logic [7:0] sfr_bit_addr,
	input  wire logic       sfr_bit_val,
	output logic      [7:0] sfr_rdata,
	input  wire logic       master_enable,
	input  wire logic       clock_phase,
	input  wire logic       clock_polarity,
	input  wire logic       port_irq_enable,
	output logic            irq_request,
	output logic            transfer_busy,
	input  wire logic       sck_in,
	output logic            sck_out,
	output logic            sck_oe,
	input  wire logic       mosi_in,
	output logic            mosi_out,
	output logic            mosi_oe,
	input  wire logic       miso_in,
	output logic            miso_out,
	output logic            miso_oe,
	input  wire logic       slave_select_line_in,
	output logic            slave_select_line_out,
	output logic            slave_select_line_oe
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [spic_pkg::SYNC_INPUTS-1:0] pin_raw;
	logic [spic_pkg::SYNC_INPUTS-1:0] pin_level;

	assign pin_raw = {slave_select_line_in, miso_in, mosi_in, sck_in};

	// Stage two and three must agree, so a one-cycle glitch never counts
	for (genvar i = 0; i < spic_pkg::SYNC_INPUTS; i++) begin : g_sync
		logic [spic_pkg::SYNC_STAGES-1:0] stage;
		always_ff @(posedge clk) begin
			if (rst) begin
				stage        <= '1;
				pin_level[i] <= 1'b1;
			end else begin
				stage <= {stage[spic_pkg::SYNC_STAGES-2:0], pin_raw[i]};
				if (stage[1] == stage[2]) begin
					pin_level[i] <= stage[2];
				end
			end
		end
	end

	logic sck_level;
	logic mosi_level;
	logic miso_level;
	logic select_level;
	assign sck_level    = pin_level[0];
	assign mosi_level   = pin_level[1];
	assign miso_level   = pin_level[2];
	assign select_level = pin_level[3];

	// ----------------------------------------
	// Register state and bus decode
	// ----------------------------------------
	logic        transfer_done_flag;
	logic        write_collision_flag;
	logic        mode_fault_flag;
	logic        receive_overrun_flag;
	logic [1:0]  slave_select_mode;
	logic        transmit_buffer_empty;
	logic        port_enable;
	logic [7:0]  clock_divider_value;
	logic [7:0]  tx_buffer;
	logic [7:0]  rx_buffer;
	logic        rx_full;

	logic        page_ok;
	logic        ctrl_byte_wr;
	logic        ctrl_bit_hit;
	logic [7:0]  ctrl_mask;
	logic [7:0]  ctrl_val;
	logic        data_wr;
	logic        data_rd;

	assign page_ok      = (sfr_page == spic_pkg::SFR_PAGE);
	assign ctrl_byte_wr = page_ok && sfr_wr && (sfr_addr == spic_pkg::ADDR_CONTROL);
	assign ctrl_bit_hit = page_ok && sfr_bit_wr
		&& (sfr_bit_addr[7:3] == spic_pkg::ADDR_CONTROL[7:3]);
	assign ctrl_mask    = ctrl_byte_wr ? 8'hff
		: (ctrl_bit_hit ? (8'h01 << sfr_bit_addr[2:0]) : 8'h00);
	assign ctrl_val     = ctrl_byte_wr ? sfr_wdata : {8{sfr_bit_val}};
	assign data_wr      = page_ok && sfr_wr && (sfr_addr == spic_pkg::ADDR_DATA);
	assign data_rd      = page_ok && sfr_rd && (sfr_addr == spic_pkg::ADDR_DATA);

	// ----------------------------------------
	// Shift engine
	// ----------------------------------------
	spic_pkg::spic_state_t state;
	logic [7:0]  shreg;
	logic [4:0]  edge_count;
	logic        out_bit;
	logic        sck_drive;
	logic        sck_prev;
	logic        rate_tick;
	logic        is_master;
	logic        selected;
	logic        fault;
	logic        edge_now;
	logic        sample_edge;
	logic        last_edge;
	logic        load_now;
	logic        xfer_end;

	assign is_master   = port_enable && master_enable;
	assign selected    = port_enable && !master_enable
		&& ((slave_select_mode == spic_pkg::MODE_3WIRE) || !select_level);
	assign fault       = port_enable && master_enable && !select_level
		&& (slave_select_mode == spic_pkg::MODE_4WIRE_IN);
	assign edge_now    = (state == spic_pkg::SPIC_RUN)
		&& (is_master ? rate_tick : (sck_level != sck_prev));
	assign sample_edge = (edge_count[0] == clock_phase);
	assign last_edge   = edge_now && (edge_count == spic_pkg::XFER_EDGES - 5'h01);
	// master starts on a full buffer
	assign load_now    = (state == spic_pkg::SPIC_IDLE) && !fault
		&& ((is_master && !transmit_buffer_empty) || selected);
	assign xfer_end    = last_edge;

	spic_rate_divider #(
		.WIDTH(8)
	) u_rate (
		.clk    (clk),
		.rst    (rst),
		.run    (is_master && (state == spic_pkg::SPIC_RUN)),
		.divider(clock_divider_value),
		.tick   (rate_tick)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			sck_prev <= 1'b1;
		end else begin
			sck_prev <= sck_level;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state      <= spic_pkg::SPIC_IDLE;
			edge_count <= 5'h00;
			shreg      <= 8'h00;
			out_bit    <= 1'b0;
			sck_drive  <= 1'b0;
		end else if (!port_enable || fault || (!is_master && !selected)) begin
			// Deselect or fault drops a partial byte
			state      <= spic_pkg::SPIC_IDLE;
			edge_count <= 5'h00;
			sck_drive  <= clock_polarity;
		end else if (load_now) begin
			state      <= spic_pkg::SPIC_RUN;
			edge_count <= 5'h00;
			shreg      <= tx_buffer;
			sck_drive  <= clock_polarity;
			if (!clock_phase) begin
				out_bit <= tx_buffer[7];
			end
		end else if (edge_now) begin
			sck_drive  <= ~sck_drive;
			edge_count <= edge_count + 5'h01;
			if (sample_edge) begin
				shreg <= {shreg[6:0], is_master ? miso_level : mosi_level};
			end else begin
				out_bit <= shreg[7];
			end
			if (last_edge) begin
				state <= spic_pkg::SPIC_IDLE;
			end
		end
	end

	// ----------------------------------------
	// Buffers
	// ----------------------------------------
	logic [7:0] rx_next;
	// Phase 0 ends on a shift edge, so the byte is already whole there
	assign rx_next = sample_edge ? {shreg[6:0], is_master ? miso_level : mosi_level} : shreg;

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_buffer             <= spic_pkg::RESET_DATA;
			transmit_buffer_empty <= spic_pkg::RESET_TRANSMIT_BUFFER_EMPTY;
		end else if (data_wr && transmit_buffer_empty) begin
			tx_buffer             <= sfr_wdata;
			transmit_buffer_empty <= 1'b0;
		end else if (load_now && !transmit_buffer_empty) begin
			transmit_buffer_empty <= 1'b1;
		end
		// a colliding write falls through untouched
	end

	// Slave overrun keeps the unread byte rather than the new one
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_buffer <= spic_pkg::RESET_DATA;
			rx_full   <= 1'b0;
		end else if (xfer_end && (is_master || !rx_full)) begin
			rx_buffer <= rx_next;
			rx_full   <= 1'b1;
		end else if (data_rd) begin
			rx_full   <= 1'b0;
		end
	end

	// ----------------------------------------
	// Status flags, set beats clear
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			transfer_done_flag   <= 1'b0;
			write_collision_flag <= 1'b0;
			mode_fault_flag      <= 1'b0;
			receive_overrun_flag <= 1'b0;
		end else begin
			transfer_done_flag   <= xfer_end
				|| (ctrl_mask[spic_pkg::BIT_DONE] ? ctrl_val[spic_pkg::BIT_DONE]
				: transfer_done_flag);
			write_collision_flag <= (data_wr && !transmit_buffer_empty)
				|| (ctrl_mask[spic_pkg::BIT_WRITE_COLLISION_FLAG] ? ctrl_val[spic_pkg::BIT_WRITE_COLLISION_FLAG]
				: write_collision_flag);
			mode_fault_flag      <= fault
				|| (ctrl_mask[spic_pkg::BIT_MODE_FAULT_FLAG] ? ctrl_val[spic_pkg::BIT_MODE_FAULT_FLAG]
				: mode_fault_flag);
			receive_overrun_flag <= (xfer_end && !is_master && rx_full)
				|| (ctrl_mask[spic_pkg::BIT_OVRN] ? ctrl_val[spic_pkg::BIT_OVRN]
				: receive_overrun_flag);
		end
	end

	// ----------------------------------------
	// Configuration fields
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			// four-wire input is the reset mode
			slave_select_mode <= spic_pkg::RESET_MODE;
			port_enable       <= 1'b0;
		end else begin
			if (ctrl_mask[spic_pkg::BIT_MODE_HI]) begin
				slave_select_mode[1] <= ctrl_val[spic_pkg::BIT_MODE_HI];
			end
			if (ctrl_mask[spic_pkg::BIT_MODE_LO]) begin
				slave_select_mode[0] <= ctrl_val[spic_pkg::BIT_MODE_LO];
			end
			if (ctrl_mask[spic_pkg::BIT_ENABLE]) begin
				port_enable <= ctrl_val[spic_pkg::BIT_ENABLE];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			clock_divider_value <= spic_pkg::RESET_DIVIDER;
		end else if (page_ok && sfr_wr && (sfr_addr == spic_pkg::ADDR_DIVIDER)) begin
			clock_divider_value <= sfr_wdata;
		end
	end

	// ----------------------------------------
	// Read port, one cycle after the strobe
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
		end else if (page_ok && sfr_rd) begin
			case (sfr_addr)
				spic_pkg::ADDR_CONTROL: sfr_rdata <= {transfer_done_flag,
					write_collision_flag, mode_fault_flag, receive_overrun_flag,
					slave_select_mode, transmit_buffer_empty, port_enable};
				spic_pkg::ADDR_DIVIDER: sfr_rdata <= clock_divider_value;
				spic_pkg::ADDR_DATA:    sfr_rdata <= rx_buffer;
				default:                sfr_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign irq_request   = port_irq_enable && (transfer_done_flag || write_collision_flag
		|| mode_fault_flag || receive_overrun_flag);
	assign transfer_busy = (state == spic_pkg::SPIC_RUN);
	assign sck_out       = sck_drive;
	assign sck_oe        = is_master;
	assign mosi_out      = out_bit;
	assign mosi_oe       = is_master;
	assign miso_out      = out_bit;
	assign miso_oe       = selected;
	// single master drives the low mode bit
	assign slave_select_line_out = slave_select_mode[0];
	assign slave_select_line_oe  = port_enable && slave_select_mode[1];
endmodule
`default_nettype wire

// [core/spic_rate_divider.sv]
// Half-period tick generator for the master serial clock.
// Assumes run is held high for the whole transfer and low otherwise.
`timescale 1ns/10ps
`default_nettype none
module spic_rate_divider #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             run,
	input  wire logic [WIDTH-1:0] divider,
	output logic                  tick
);
	logic [WIDTH-1:0] count;

	// half period of divider plus one
	always_ff @(posedge clk) begin
		if (rst || !run || tick) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	assign tick = run && (count == divider);
endmodule
`default_nettype wire

// [pkg/spic_pkg.sv]
// Package for the serial port control and clock-rate block.
// Assumes an 8-bit special function register bus on the system clock.
package spic_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] SFR_PAGE      = 4'h0;
	localparam logic [7:0] ADDR_DIVIDER  = 8'ha2;
	localparam logic [7:0] ADDR_DATA     = 8'ha3;
	localparam logic [7:0] ADDR_CONTROL  = 8'hf8;
	localparam logic [7:0] RESET_DIVIDER = 8'h00;
	localparam logic [7:0] RESET_DATA    = 8'h00;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int          BIT_DONE      = 7;
	localparam int          BIT_WRITE_COLLISION_FLAG      = 6;
	localparam int          BIT_MODE_FAULT_FLAG      = 5;
	localparam int          BIT_OVRN      = 4;
	localparam int          BIT_MODE_HI   = 3;
	localparam int          BIT_MODE_LO   = 2;
	localparam int          BIT_TRANSMIT_BUFFER_EMPTY     = 1;
	localparam int          BIT_ENABLE    = 0;
	localparam logic [1:0]  MODE_3WIRE    = 2'b00;
	localparam logic [1:0]  MODE_4WIRE_IN = 2'b01;
	localparam logic [1:0]  RESET_MODE    = 2'b01;
	localparam logic        RESET_TRANSMIT_BUFFER_EMPTY   = 1'b1;

	// ----------------------------------------
	// Transfer engine
	// ----------------------------------------
	localparam logic [4:0]  XFER_EDGES    = 5'h10;
	localparam int          SYNC_STAGES   = 3;
	localparam int          SYNC_INPUTS   = 4;

	typedef enum logic [0:0] {
		SPIC_IDLE = 1'b0,
		SPIC_RUN  = 1'b1
	} spic_state_t;
endpackage

// [verification/spic_control_sva.sv]
// Port checker for the serial port control block.
// Assumes it is bound to spic_control and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module spic_control_sva (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [3:0] sfr_page,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_bit_wr,
	input wire logic [7:0] sfr_bit_addr,
	input wire logic       sfr_bit_val,
	input wire logic       master_enable,
	input wire logic       port_irq_enable,
	input wire logic       irq_request,
	input wire logic       transfer_busy,
	input wire logic       sck_out,
	input wire logic       sck_oe,
	input wire logic       miso_oe,
	input wire logic       slave_select_line_out,
	input wire logic       slave_select_line_oe
);
	// ------
	// Shadow of software-owned control bits
	// ------
	logic [1:0] sh_mode;
	logic       sh_en;
	logic       seen;
	logic       ctl_wr;
	logic       bit_wr;
	logic [7:0] sh_div;
	logic [7:0] cnt;
	assign ctl_wr = sfr_wr && sfr_page == 4'h0 && sfr_addr == 8'hf8;
	assign bit_wr = sfr_bit_wr && sfr_page == 4'h0 && sfr_bit_addr[7:3] == 5'h1f;
	always_ff @(posedge clk) begin
		if (rst) begin
			sh_mode <= 2'h1;
			sh_en   <= 1'b0;
		end else if (ctl_wr) begin
			sh_mode <= sfr_wdata[3:2];
			sh_en   <= sfr_wdata[0];
		end else if (bit_wr && sfr_bit_addr[2:0] == 3'h0) begin
			sh_en <= sfr_bit_val;
		end else if (bit_wr && sfr_bit_addr[2:1] == 2'h1) begin
			sh_mode[sfr_bit_addr[0]] <= sfr_bit_val;
		end
	end
	always_ff @(posedge clk) begin
		if (rst)
			sh_div <= 8'h00;
		else if (sfr_wr && sfr_page == 4'h0 && sfr_addr == 8'ha2)
			sh_div <= sfr_wdata;
	end
	// Counter only judged between two toggles of one transfer
	always_ff @(posedge clk) begin
		if (rst || $changed(sck_out))
			cnt <= 8'h00;
		else
			cnt <= cnt + 8'h01;
		if (rst || !transfer_busy)
			seen <= 1'b0;
		else if ($changed(sck_out))
			seen <= 1'b1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sel_enable_a: assert property (slave_select_line_oe == (sh_en && sh_mode[1]))
		else $error("select enable wrong");
	sel_level_a: assert property (slave_select_line_oe |-> slave_select_line_out == sh_mode[0])
		else $error("select level wrong");
	sck_drive_a: assert property (sck_oe == (sh_en && master_enable))
		else $error("clock enable wrong");
	half_period_a: assert property ($changed(sck_out) && seen |-> cnt == sh_div)
		else $error("half period wrong");
	disabled_idle_a: assert property (!sh_en && !$past(sh_en) |-> !transfer_busy)
		else $error("busy while disabled");
	master_start_a: assert property (sfr_wr && sfr_page == 4'h0 && sfr_addr == 8'ha3 && sh_en
		&& sh_mode[1] && master_enable && !transfer_busy |-> ##[1:3] transfer_busy)
		else $error("transfer not started");
	irq_gate_a: assert property (irq_request |-> port_irq_enable)
		else $error("irq without enable");
	irq_sticky_a: assert property ($fell(irq_request) |-> !port_irq_enable || $past(ctl_wr) || $past(bit_wr))
		else $error("flag cleared by itself");
	done_irq_a: assert property ($fell(transfer_busy) && sh_en && port_irq_enable && master_enable |-> ##[0:2] irq_request)
		else $error("no irq at end");
	slave_out_a: assert property (miso_oe |-> !master_enable)
		else $error("slave output in master");
	cover property ($rose(transfer_busy));
	cover property ($rose(irq_request));
	cover property ($rose(slave_select_line_oe));
endmodule
bind spic_control spic_control_sva chk_u (.clk, .rst, .sfr_page, .sfr_addr, .sfr_wr, .sfr_wdata,
	.sfr_bit_wr, .sfr_bit_addr, .sfr_bit_val, .master_enable, .port_irq_enable, .irq_request,
	.transfer_busy, .sck_out, .sck_oe, .miso_oe, .slave_select_line_out, .slave_select_line_oe);
`default_nettype wire

// [verification/spic_slave_model.sv]
// Behavioural serial slave on the far side, mode 0 timing.
// Assumes a master clock idling low and an active-low select.
`timescale 1ns/10ps
`default_nettype none
module spic_slave_model (
	input  wire logic       clk,
	input  wire logic       sck,
	input  wire logic       sel_n,
	input  wire logic       mosi,
	input  wire logic [7:0] tx_byte,
	output logic            miso,
	output logic      [7:0] rx_byte
);
	// ------
	// Shift logic
	// ------
	logic       sck_q = 1'b0;
	logic       junk = 1'b0;
	logic [2:0] cnt = 3'h0;
	// Released line toggles so a stale bit is never mistaken for data
	assign miso = sel_n ? junk : tx_byte[3'h7 - cnt];
	always @(posedge clk) begin
		sck_q <= sck;
		junk  <= ~junk;
		if (sel_n)
			cnt <= 3'h0;
		else if (sck_q && !sck)
			cnt <= cnt + 3'h1;
		if (!sel_n && !sck_q && sck)
			rx_byte <= {rx_byte[6:0], mosi};
	end
endmodule
`default_nettype wire

// [verification/tb_spi_control_and_clock_rate.sv]
// Self-checking bench for the serial port control block.
// Assumes the slave model on the link and mode 0 clocking.
`timescale 1ns/10ps
`default_nettype none
module tb_spi_control_and_clock_rate;
	logic       clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_wr = 1'b0;
	logic       sfr_bit_val = 1'b0, master_enable = 1'b0, port_irq_enable = 1'b0, ss_drv = 1'b1;
	logic [3:0] sfr_page = 4'h0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00, tx_byte = 8'h00;
	logic [7:0] d_byte, e_byte, exp_q[$];
	wire logic [7:0] sfr_rdata, rx_byte;
	wire logic  irq_request, transfer_busy, sck_in, sck_out, sck_oe, mosi_in, mosi_out, mosi_oe;
	wire logic  miso_in, miso_out, miso_oe;
	wire logic  slave_select_line_in, slave_select_line_out, slave_select_line_oe;
	string      nm_q[$];
	logic       rd_seen = 1'b0;
	int         n_fail = 0, n_compared = 0, seed = 6484, cyc = 0;
	// ------
	// Wiring, clock and checks
	// ------
	assign slave_select_line_in = slave_select_line_oe ? slave_select_line_out : ss_drv;
	assign sck_in = sck_out & sck_oe;
	assign mosi_in = mosi_out & mosi_oe;
	spic_control dut_u (.clk, .rst, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_bit_wr,
		.sfr_bit_addr, .sfr_bit_val, .sfr_rdata, .master_enable, .clock_phase(1'b0),
		.clock_polarity(1'b0), .port_irq_enable, .irq_request, .transfer_busy, .sck_in, .sck_out,
		.sck_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe,
		.slave_select_line_in, .slave_select_line_out, .slave_select_line_oe);
	spic_slave_model far_u (.clk, .sck(sck_out), .sel_n(slave_select_line_in), .mosi(mosi_out),
		.tx_byte, .miso(miso_in), .rx_byte);
	always #5 clk = ~clk;
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic give_verdict;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_addr  <= a;
		sfr_wdata <= d;
		sfr_wr    <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic bw(input logic [2:0] i, input logic v);
		@(posedge clk);
		sfr_bit_addr <= {5'h1f, i};
		sfr_bit_val  <= v;
		sfr_bit_wr   <= 1'b1;
		@(posedge clk);
		sfr_bit_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		exp_q.push_back(e);
		nm_q.push_back(nm);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
	endtask
	task automatic wait_busy(input logic v);
		for (int i = 0; i < 400 && transfer_busy !== v; i++)
			@(posedge clk);
		chk1("busy", v, transfer_busy);
	endtask
	// Read data lands one cycle after the strobe
	always @(posedge clk) begin
		rd_seen <= sfr_rd;
		if (rd_seen && exp_q.size() > 0)
			chk8(nm_q.pop_front(), exp_q.pop_front(), sfr_rdata);
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			give_verdict;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(8'hf8, 8'h06, "ctl");
		rd(8'ha2, 8'h00, "div");
		rd(8'h55, 8'h00, "unmapped");
		wr(8'ha2, 8'h07);
		sfr_page <= 4'h1;
		rd(8'hf8, 8'h00, "page1");
		wr(8'ha2, 8'h33);
		sfr_page <= 4'h0;
		rd(8'ha2, 8'h07, "div");
		for (int m = 0; m < 4; m++) begin
			wr(8'hf8, {4'h0, m[1:0], 2'h1});
			repeat (5) @(posedge clk);
			chk1("sel_oe", m[1], slave_select_line_oe);
			chk1("miso_oe", !m[0], miso_oe);
			if (m[1])
				chk1("sel_out", m[0], slave_select_line_out);
		end
		wr(8'hf8, 8'h08);
		master_enable   <= 1'b1;
		port_irq_enable <= 1'b1;
		d_byte = 8'($random(seed));
		e_byte = ~d_byte;
		tx_byte <= 8'($random(seed));
		wr(8'ha3, d_byte);
		repeat (10) @(posedge clk);
		chk1("busy", 1'b0, transfer_busy);
		rd(8'hf8, 8'h08, "ctl");
		wr(8'ha3, e_byte);
		rd(8'hf8, 8'h48, "ctl");
		wr(8'hf8, 8'h49);
		wait_busy(1'b1);
		chk1("mosi_oe", 1'b1, mosi_oe);
		wait_busy(1'b0);
		repeat (3) @(posedge clk);
		rd(8'hf8, 8'hcb, "ctl");
		chk1("irq", 1'b1, irq_request);
		rd(8'ha3, tx_byte, "data");
		chk8("sent", d_byte, rx_byte);
		bw(3'h7, 1'b0);
		bw(3'h6, 1'b0);
		rd(8'hf8, 8'h0b, "ctl");
		chk1("irq", 1'b0, irq_request);
		wr(8'ha3, e_byte);
		wait_busy(1'b1);
		wait_busy(1'b0);
		repeat (3) @(posedge clk);
		chk8("sent", e_byte, rx_byte);
		rd(8'hf8, 8'h8b, "ctl");
		wr(8'hf8, 8'h05);
		ss_drv <= 1'b0;
		repeat (8) @(posedge clk);
		rd(8'hf8, 8'h27, "ctl");
		chk1("irq", 1'b1, irq_request);
		ss_drv <= 1'b1;
		repeat (8) @(posedge clk);
		rd(8'hf8, 8'h27, "ctl");
		wr(8'hf8, 8'h05);
		rd(8'hf8, 8'h07, "ctl");
		repeat (3) @(posedge clk);
		give_verdict;
	end
endmodule
`default_nettype wire
